//--- imsr_pkg.sv
package imsr_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_SOURCE_NUMBER  = 32'hB800_2110;
  localparam logic [31:0] ADDR_CHANNEL_MASK   = 32'hB800_2114;
  localparam logic [31:0] ADDR_OUTPUT_STATUS  = 32'hB800_2118;
  localparam logic [31:0] ADDR_MASK_SET_CMD   = 32'hB800_2120;
  localparam logic [31:0] ADDR_MASK_CLEAR_CMD = 32'hB800_2124;
  localparam logic [31:0] ADDR_SERVICE_DONE   = 32'hB800_2130;
  localparam logic [31:0] ADDR_EVENT_STATUS   = 32'hB800_2140;
  localparam logic [31:0] ADDR_EVENT_MASK     = 32'hB800_2144;

  // ------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------
  localparam int          CH_W             = 5;
  localparam logic [31:0] CHAN_BITS        = 32'hFFFF_FFFE;
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  localparam int          OS_FAST_BIT      = 0;
  localparam int          OS_NORMAL_BIT    = 1;
  localparam int          EV_GRANT_BIT     = 0;
  localparam int          EV_DONE_BIT      = 1;
  localparam int          EV_W             = 2;

  // ------------------------------------------------------------
  // block state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0]      channel_mask;
    logic [CH_W-1:0]  source_number;
    logic             in_service;
    logic             fast_irq_line_n;
    logic             normal_irq_line_n;
    logic [EV_W-1:0]  event_status;
    logic [EV_W-1:0]  event_mask;
    logic             irq;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } imsr_state_t;

  localparam imsr_state_t STATE_RESET = '{
    channel_mask:      RESET_WORD,
    source_number:     '0,
    in_service:        1'b0,
    fast_irq_line_n:   1'b1,
    normal_irq_line_n: 1'b1,
    event_status:      '0,
    event_mask:        '0,
    irq:               1'b0,
    prdata:            RESET_WORD,
    pready:            1'b0,
    pslverr:           1'b0
  };

endpackage

//--- imsr_regs.sv
// Contract
// - source number holds winning channel, read-only
// - channel number in bits 4:0, resets zero
// - active state independent of enable bit
// - grant only to active and enabled channel
// - mask register shows enables bits 31:1
// - writing one to set command enables channel
// - writing one to clear command disables channel
// - output status bit1 normal, bit0 fast
// - both status bits zero when idle
// - any write to done ends service
// - winner copied to source number on grant
// - level zero gives fast, else normal
// - pending means active and enabled together
//
// Implementation choice: the APB slave port.
module imsr_regs
  import imsr_pkg::*;
#(
  parameter int LEVEL_W = 3
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // channel state from source logic
  input  wire logic [31:1]                  chan_active,
  input  wire logic [31:1][LEVEL_W-1:0]     chan_level,
  // processor lines and block interrupt
  output logic                              fast_irq_line_n,
  output logic                              normal_irq_line_n,
  output logic                              irq
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (LEVEL_W < 1 || LEVEL_W > 8) begin : g_bad_level
    $error("imsr_regs: LEVEL_W must be 1 to 8");
  end

  // ------------------------------------------------------------
  // priority selection
  // ------------------------------------------------------------
  // lowest level wins; among equal levels the lower channel wins
  function automatic logic [CH_W-1:0] pick_winner(
    input logic [31:1]              pend,
    input logic [31:1][LEVEL_W-1:0] lvl
  );
    logic [CH_W-1:0]    best;
    logic [LEVEL_W-1:0] best_lvl;
    logic               found;
    best     = '0;
    best_lvl = '0;
    found    = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (pend[i] && (!found || lvl[i] < best_lvl)) begin
        best     = CH_W'(i);
        best_lvl = lvl[i];
        found    = 1'b1;
      end
    end
    return best;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    return a == b;
  endfunction

  imsr_state_t st;
  imsr_state_t next_st;

  logic [31:1]     pending;
  logic [CH_W-1:0] winner;
  logic            win_fast;
  logic            setup;
  logic            wr_done;
  logic            mapped;
  logic [31:0]     rd_word;

  assign pending  = chan_active & st.channel_mask[31:1];
  assign winner   = pick_winner(pending, chan_level);
  assign win_fast = (chan_level[winner] == '0);

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && st.pready && pwrite;

  assign mapped = hit(paddr, ADDR_SOURCE_NUMBER)
               || hit(paddr, ADDR_CHANNEL_MASK)
               || hit(paddr, ADDR_OUTPUT_STATUS)
               || hit(paddr, ADDR_MASK_SET_CMD)
               || hit(paddr, ADDR_MASK_CLEAR_CMD)
               || hit(paddr, ADDR_SERVICE_DONE)
               || hit(paddr, ADDR_EVENT_STATUS)
               || hit(paddr, ADDR_EVENT_MASK);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_word = RESET_WORD;
    case (1'b1)
      hit(paddr, ADDR_SOURCE_NUMBER): begin
        rd_word[CH_W-1:0] = st.source_number;
      end
      hit(paddr, ADDR_CHANNEL_MASK): begin
        rd_word = st.channel_mask & CHAN_BITS;
      end
      hit(paddr, ADDR_OUTPUT_STATUS): begin
        rd_word[OS_FAST_BIT]   = ~st.fast_irq_line_n;
        rd_word[OS_NORMAL_BIT] = ~st.normal_irq_line_n;
      end
      hit(paddr, ADDR_EVENT_STATUS): begin
        rd_word[EV_W-1:0] = st.event_status;
      end
      hit(paddr, ADDR_EVENT_MASK): begin
        rd_word[EV_W-1:0] = st.event_mask;
      end
      default: begin
        rd_word = RESET_WORD;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] ev_clr;

  always_comb begin
    next_st = st;
    ev      = '0;
    ev_clr  = '0;

    // apb: answer one cycle after setup, write lands at access edge
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    next_st.prdata  = (setup && !pwrite) ? rd_word : st.prdata;

    if (wr_done) begin
      if (hit(paddr, ADDR_MASK_SET_CMD)) begin
        next_st.channel_mask = st.channel_mask | (pwdata & CHAN_BITS);
      end
      if (hit(paddr, ADDR_MASK_CLEAR_CMD)) begin
        next_st.channel_mask = st.channel_mask & ~(pwdata & CHAN_BITS);
      end
      if (hit(paddr, ADDR_EVENT_STATUS)) begin
        ev_clr = pwdata[EV_W-1:0];
      end
      if (hit(paddr, ADDR_EVENT_MASK)) begin
        next_st.event_mask = pwdata[EV_W-1:0];
      end
    end

    if (wr_done && hit(paddr, ADDR_SERVICE_DONE) && st.in_service) begin
      next_st.in_service        = 1'b0;
      next_st.fast_irq_line_n   = 1'b1;
      next_st.normal_irq_line_n = 1'b1;
      ev[EV_DONE_BIT]           = 1'b1;
    end else if (!st.in_service && |pending) begin
      next_st.source_number     = winner;
      next_st.in_service        = 1'b1;
      next_st.fast_irq_line_n   = !win_fast;
      next_st.normal_irq_line_n = win_fast;
      ev[EV_GRANT_BIT]          = 1'b1;
    end

    // a new event beats a clear in the same cycle
    next_st.event_status = (st.event_status & ~ev_clr) | ev;
    next_st.irq          = |(next_st.event_status & next_st.event_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign fast_irq_line_n   = st.fast_irq_line_n;
  assign normal_irq_line_n = st.normal_irq_line_n;
  assign irq               = st.irq;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_idle_pending;
    !st.in_service && (|pending);
  endsequence

  sequence s_done_write;
    wr_done && hit(paddr, ADDR_SERVICE_DONE) && st.in_service;
  endsequence

  grant_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_idle_pending and !(wr_done && hit(paddr, ADDR_SERVICE_DONE))
    |=> st.in_service && st.source_number == $past(winner))
    else $error("winner not latched on grant");

  grant_enabled_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.in_service)
    |-> $past(pending[winner]) && st.source_number == $past(winner))
    else $error("grant to channel not active and enabled");

  line_class_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.in_service)
    |-> (st.fast_irq_line_n == ($past(chan_level[winner]) != '0))
        && (st.normal_irq_line_n != st.fast_irq_line_n))
    else $error("wrong line for winner level");

  idle_lines_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st.in_service |-> st.fast_irq_line_n && st.normal_irq_line_n)
    else $error("line active while idle");

  done_release_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_done_write |=> !st.in_service ##0 st.fast_irq_line_n
                     ##0 st.normal_irq_line_n)
    else $error("service not ended by done write");

  mask_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit(paddr, ADDR_MASK_SET_CMD)
    |=> st.channel_mask == ($past(st.channel_mask)
                            | ($past(pwdata) & CHAN_BITS)))
    else $error("set command mismatch");

  mask_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit(paddr, ADDR_MASK_CLEAR_CMD)
    |=> st.channel_mask == ($past(st.channel_mask)
                            & ~($past(pwdata) & CHAN_BITS)))
    else $error("clear command mismatch");

  status_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit(paddr, ADDR_OUTPUT_STATUS)
    |=> st.pready ##0 st.prdata == {30'h0,
        ~$past(st.normal_irq_line_n), ~$past(st.fast_irq_line_n)})
    else $error("output status readback wrong");

  mask_bit0_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.channel_mask[0] == 1'b0)
    else $error("reserved mask bit set");

  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.irq == |(st.event_status & st.event_mask))
    else $error("interrupt output disagrees with status");

  // ------------------------------------------------------------
  // bus and hold assertions
  // ------------------------------------------------------------
  // the answer is fixed one cycle after setup, so no wait state is
  // ever inserted and a master may rely on the access cycle alone
  bus_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> st.pready && (st.pslverr == !$past(mapped)))
    else $error("no answer one cycle after setup");

  bus_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !setup |=> !st.pready && !st.pslverr)
    else $error("answer without setup");

  source_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit(paddr, ADDR_SOURCE_NUMBER)
    |=> st.prdata == {{(32-CH_W){1'b0}}, $past(st.source_number)})
    else $error("source number readback wrong");

  mask_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit(paddr, ADDR_CHANNEL_MASK)
    |=> st.prdata == ($past(st.channel_mask) & CHAN_BITS))
    else $error("mask readback wrong");

  // only the two command registers may move the enables; activity
  // of a channel must never leak into its enable bit
  mask_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(wr_done && (hit(paddr, ADDR_MASK_SET_CMD)
                  || hit(paddr, ADDR_MASK_CLEAR_CMD)))
    |=> $stable(st.channel_mask))
    else $error("enables changed without a command");

  no_grant_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st.in_service && !(|pending) |=> !st.in_service)
    else $error("grant with nothing pending");

  one_line_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.in_service |-> st.fast_irq_line_n != st.normal_irq_line_n)
    else $error("not exactly one line low in service");

  // a second grant while one is in service would overwrite the number
  // that the handler is still using
  busy_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.in_service && !(wr_done && hit(paddr, ADDR_SERVICE_DONE))
    |=> st.in_service && $stable(st.source_number))
    else $error("service ended or number moved without done write");

  grant_event_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.in_service) |-> st.event_status[EV_GRANT_BIT])
    else $error("grant event not recorded");

  event_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && hit(paddr, ADDR_EVENT_STATUS)
    |=> st.event_status == (($past(st.event_status)
                             & ~$past(pwdata[EV_W-1:0])) | $past(ev)))
    else $error("event clear or set wrong");

endmodule

//--- imsr_core_model.sv
module imsr_core_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // processor interrupt inputs
  input  wire logic       fast_n,
  input  wire logic       norm_n,
  // handler entry delay, lines taken
  input  wire logic [3:0] lat,
  output logic      [1:0] taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // a low line is a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= '0;
      taken <= '0;
    end else if (fast_n && norm_n) begin
      cnt   <= '0;
      taken <= '0;
    end else if (cnt >= lat) begin
      taken <= {~norm_n, ~fast_n};
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

//--- tb.sv
module tb
  import imsr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] RSVD = 32'hF2D8_0C70;
  logic             pclk = 1'b0;
  logic             presetn, psel, penable, pwrite, pready, pslverr;
  logic             fast_n, norm_n, irq, err;
  logic [31:0]      paddr, pwdata, prdata, rdat;
  // xorshift state starts at 21255
  logic [31:0]      seed = 32'h0000_5307;
  logic [31:1]      act;
  logic [31:1][2:0] lvl;
  logic [3:0]       lat;
  logic [1:0]       taken;
  int               n_mismatch = 0;
  int               tests_run = 0;

  always #10 pclk = ~pclk;

  imsr_regs #(.LEVEL_W(3)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_active(act),
    .chan_level(lvl), .fast_irq_line_n(fast_n),
    .normal_irq_line_n(norm_n), .irq(irq)
  );
  imsr_core_model i_core (
    .pclk(pclk), .presetn(presetn), .fast_n(fast_n), .norm_n(norm_n),
    .lat(lat), .taken(taken)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, e);
    apb(1'b0, a, '0);
    chk(nm, e, rdat);
  endtask

  initial begin
    logic [31:0]      m, s, c, a, pend, o, last;
    logic [31:1][2:0] lv;
    int               win, k;
    m = '0;
    last = '0;
    {presetn, psel, penable, pwrite} = '0;
    {paddr, pwdata, act, lvl, lat} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("source_number", ADDR_SOURCE_NUMBER, '0);
    rdc("channel_mask", ADDR_CHANNEL_MASK, '0);
    rdc("output_status", ADDR_OUTPUT_STATUS, '0);
    chk("mapped err", '0, {31'b0, err});
    apb(1'b1, ADDR_SERVICE_DONE, '0);
    rdc("idle done", ADDR_EVENT_STATUS, '0);
    apb(1'b1, ADDR_CHANNEL_MASK, '1);
    rdc("mask read only", ADDR_CHANNEL_MASK, '0);
    apb(1'b0, ADDR_OUTPUT_STATUS + 32'h0000_0004, '0);
    chk("unmapped err", 32'h0000_0001, {31'b0, err});
    for (int i = 0; i < 8; i++) begin
      s = xs();
      lat <= s[3:0];
      apb(1'b1, ADDR_EVENT_MASK, i[0] ? 32'h0000_0003 : '0);
      s = xs() & CHAN_BITS & ~RSVD;
      m |= s;
      apb(1'b1, ADDR_MASK_SET_CMD, s | 32'h0000_0001);
      rdc("mask set", ADDR_CHANNEL_MASK, m);
      c = xs() & xs();
      m &= ~c;
      apb(1'b1, ADDR_MASK_CLEAR_CMD, c);
      rdc("mask clear", ADDR_CHANNEL_MASK, m);
      a = (i == 0) ? ~m : xs();
      for (int ch = 1; ch < 32; ch++) begin
        s = xs();
        lv[ch] = i[0] ? 3'(s % 7 + 1) : s[2:0];
      end
      pend = a & m & CHAN_BITS;
      win = 0;
      for (int ch = 31; ch > 0; ch--) begin
        if (pend[ch] && (win == 0 || lv[ch] <= lv[win])) win = ch;
      end
      if (win != 0) last = 32'(win);
      lvl <= lv;
      act <= a[31:1];
      for (k = 0; k < 40 && taken === 2'b00; k++) @(posedge pclk);
      if (win != 0 && k == 40) begin
        n_mismatch++;
        tally_and_finish();
      end
      o = {30'b0, win != 0 && lv[win] != 0, win != 0 && lv[win] == 0};
      chk("core taken", o, {30'b0, taken});
      chk("lines", o, {30'b0, ~norm_n, ~fast_n});
      rdc("output_status", ADDR_OUTPUT_STATUS, o);
      rdc("event status", ADDR_EVENT_STATUS, {31'b0, win != 0});
      chk("irq", {31'b0, win != 0 && i[0]}, {31'b0, irq});
      rdc("source_number", ADDR_SOURCE_NUMBER, last);
      act <= '0;
      if (win != 0) begin
        apb(1'b1, ADDR_SERVICE_DONE, xs());
        @(posedge pclk);
        chk("lines idle", 32'h0000_0003, {30'b0, norm_n, fast_n});
        rdc("status idle", ADDR_OUTPUT_STATUS, '0);
        rdc("event done", ADDR_EVENT_STATUS, 32'h0000_0003);
      end
      apb(1'b1, ADDR_EVENT_STATUS, 32'h0000_0003);
      rdc("event cleared", ADDR_EVENT_STATUS, '0);
      chk("irq cleared", '0, {31'b0, irq});
    end
    apb(1'b1, ADDR_MASK_SET_CMD, CHAN_BITS & ~RSVD);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rdc("mask after reset", ADDR_CHANNEL_MASK, '0);
    chk("lines after reset", 32'h0000_0003, {30'b0, norm_n, fast_n});
    tally_and_finish();
  end
endmodule
